// file: dv/drive_monitor_model.sv
// far-side model: gate drivers and the system monitor on the power good wire
`timescale 1ns/10ps
`default_nettype none
module drive_monitor_model (
  input  wire logic                        sys_clk,
  input  wire logic                        power_good_out,
  input  wire logic                        power_good_oe,
  input  wire fault_sup_pkg::pwm_mode_type pwm_mode,
  input  wire logic         crowbar_gate_out,
  output logic              power_good_out_wire,
  output logic              lower_on,
  output logic              rail_fired
);
  import fault_sup_pkg::*;
  // ************************************************************
  // wire resolution and driver response
  // ************************************************************
  // open-drain line with a pull-up: released means high, never the last value
  assign power_good_out_wire = power_good_oe ? power_good_out : 1'b1;
  // drivers turn the lower switches on only for a forced-low command
  assign lower_on = (pwm_mode == PWM_LOW);
  // the external crowbar stays fired once gated, as a blown fuse would
  always @(posedge sys_clk) begin
    if (crowbar_gate_out) begin
      rail_fired <= 1'b1;
    end
  end
  initial rail_fired = 1'b0;
endmodule
`default_nettype wire

// file: dv/fault_supervisor_bench.sv
// self-checking bench for the multiphase fault supervisor
`timescale 1ns/10ps
`default_nettype none
module multiphase_fault_supervisor_bench;
  import fault_sup_pkg::*;
  logic           sys_clk, reset_n, phase_tick, psel, penable, pwrite;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, q;
  logic           pready, pslverr, power_good_out, power_good_oe, crowbar_gate_out;
  logic           power_good_out_wire, lower_on, rail_fired, e;
  comp_flags_type f;
  pwm_mode_type   pwm_mode;
  int             miscompares, n_tests;

  fault_supervisor #(.RETRY_LIMIT(7)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .phase_tick(phase_tick), .comp_flags(f), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_good_out(power_good_out), .power_good_oe(power_good_oe),
    .crowbar_gate_out(crowbar_gate_out), .pwm_mode(pwm_mode));
  drive_monitor_model i_far (.sys_clk(sys_clk), .power_good_out(power_good_out),
    .power_good_oe(power_good_oe), .pwm_mode(pwm_mode), .crowbar_gate_out(crowbar_gate_out),
    .power_good_out_wire(power_good_out_wire), .lower_on(lower_on), .rail_fired(rail_fired));

  // ************************************************************
  // common tasks
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // flags need three edges to reach the outputs; read before the edge launches anything
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // apb transfer: hold everything until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic state_is(input sup_state_type s);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check("state", 32'(q[2:0]), 32'(s));
  endtask
  // poll the state field under a bounded count
  task automatic wait_st(input sup_state_type s);
    for (int i = 0; i < 1500; i++) begin
      apb(1'b0, STATUS_OFFSET, 32'h0);
      if (q[2:0] === s) break;
    end
    check("state reached", 32'(q[2:0]), 32'(s));
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    apb(1'b0, CTRL_OFFSET, 32'h0);
    check("ctrl", q, 32'(CTRL_RESET_VALUE));
    apb(1'b1, STATUS_OFFSET, 32'hff);
    state_is(ST_SHUTDOWN);
    apb(1'b0, 12'h00c, 32'h0);
    check("slverr", 32'(e), 32'h1);
    check("power_good_out", 32'(power_good_out_wire), 32'h0);
    check("power_good_out data", 32'(power_good_out), 32'h0);
  endtask
  task automatic t_start;
    f.enable_ok <= 1'b1; f.bias_ok <= 1'b1; f.under_voltage <= 1'b1;
    tick(6);
    state_is(ST_SOFTSTART);
    check("power_good_out", 32'(power_good_out_wire), 32'h0);
    f.under_voltage <= 1'b0;
    tick(4);
    check("power_good_out", 32'(power_good_out_wire), 32'h1);
    tick(1800);
    state_is(ST_SOFTSTART);
    wait_st(ST_RUN);
    check("pwm", 32'(pwm_mode), 32'(PWM_NORMAL));
  endtask
  task automatic t_uv;
    f.under_voltage <= 1'b1;
    tick(4);
    check("power_good_out", 32'(power_good_out_wire), 32'h0);
    check("pwm", 32'(pwm_mode), 32'(PWM_NORMAL));
    f.under_voltage <= 1'b0;
    tick(4);
    check("power_good_out", 32'(power_good_out_wire), 32'h1);
    // a current surge during a code step must not trip
    f.code_transition <= 1'b1; f.over_current <= 1'b1;
    tick(8);
    state_is(ST_RUN);
    f.over_current <= 1'b0;
    tick(4);
    f.code_transition <= 1'b0;
  endtask
  task automatic t_disable;
    f.enable_ok <= 1'b0;
    tick(8);
    check("power_good_out", 32'(power_good_out_wire), 32'h1);
    f.under_voltage <= 1'b1;
    tick(4);
    check("power_good_out", 32'(power_good_out_wire), 32'h0);
    f.enable_ok <= 1'b1; f.under_voltage <= 1'b0;
  endtask
  task automatic trip;
    f.over_current <= 1'b1;
    tick(4);
    f.over_current <= 1'b0;
    check("pwm", 32'(pwm_mode), 32'(PWM_HIZ));
    check("power_good_out", 32'(power_good_out_wire), 32'h0);
  endtask
  task automatic t_oc;
    tick(6);
    trip;
    tick(1900);
    state_is(ST_OC_WAIT);
    wait_st(ST_RUN);
    apb(1'b0, RETRY_OFFSET, 32'h0);
    check("retry", 32'(q[2:0]), 32'h0);
    for (int k = 1; k <= 8; k++) begin
      if (k > 1) wait_st(ST_SOFTSTART);
      trip;
      apb(1'b0, RETRY_OFFSET, 32'h0);
      if (k < 8) check("retry", 32'(q[2:0]), 32'(k));
      if (k < 8) state_is(ST_OC_WAIT);
    end
    tick(2200);
    state_is(ST_OC_LATCH);
    f.enable_ok <= 1'b0;
    tick(5);
    state_is(ST_SHUTDOWN);
    f.enable_ok <= 1'b1;
  endtask
  task automatic t_ov;
    tick(8);
    f.over_voltage <= 1'b1;
    tick(4);
    f.over_voltage <= 1'b0;
    check("power_good_out", 32'(power_good_out_wire), 32'h0);
    check("pwm", 32'(pwm_mode), 32'(PWM_LOW));
    check("lower on", 32'(lower_on), 32'h1);
    check("crowbar", 32'(crowbar_gate_out), 32'h1);
    state_is(ST_OV_LATCH);
    check("rail fired", 32'(rail_fired), 32'h1);
    f.at_reference <= 1'b1;
    tick(4);
    check("pwm", 32'(pwm_mode), 32'(PWM_HIZ));
    f.at_reference <= 1'b0; f.over_voltage <= 1'b1;
    tick(4);
    check("pwm", 32'(pwm_mode), 32'(PWM_LOW));
    f.over_voltage <= 1'b0;
    tick(20);
    check("power_good_out", 32'(power_good_out_wire), 32'h0);
    f.bias_ok <= 1'b0;
    tick(5);
    state_is(ST_SHUTDOWN);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    miscompares = 0; n_tests = 0; reset_n = 1'b0; phase_tick = 1'b1;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    f = '0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset; t_start; t_uv; t_disable; t_oc; t_ov;
    results;
  end
  // the hiccup chain dominates the run at about 23000 cycles
  initial begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    results;
  end
endmodule
`default_nettype wire

// file: rtl/fault_sup_pkg.sv
// constants, types and register map for the multiphase fault supervisor
package fault_sup_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] RETRY_OFFSET  = 12'h008;

  // control field positions
  localparam int CTRL_SOFT_EN_BIT = 0;
  localparam int CTRL_BLANK_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET_VALUE = 2'h3;

  // ************************************************************
  // timing counts
  // ************************************************************
  localparam int SS_COUNT_BITS = 11;
  localparam logic [10:0] SS_LAST_COUNT  = 11'h7ff;  // 2048 phase clocks
  localparam logic [10:0] WAIT_LAST_COUNT = 11'h7ff; // 2048 phase clocks
  localparam logic [2:0] MAX_RETRIES = 3'h7;         // seven hiccups

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_SHUTDOWN  = 3'b000,
    ST_SOFTSTART = 3'b001,
    ST_RUN       = 3'b010,
    ST_OC_WAIT   = 3'b011,
    ST_OC_LATCH  = 3'b100,
    ST_OV_LATCH  = 3'b101
  } sup_state_type;

  typedef enum logic [1:0] {
    PWM_NORMAL = 2'b00,
    PWM_LOW    = 2'b01,
    PWM_HIZ    = 2'b10
  } pwm_mode_type;

  // comparator flags from the analog front end
  typedef struct packed {
    logic under_voltage;    // output below undervoltage threshold
    logic over_voltage;     // diff_sense_voltage above 2.2 V
    logic at_reference;     // diff_sense_voltage at or below reference
    logic over_current;     // average_phase_current above 90 uA
    logic enable_ok;        // enable comparator above 1.23 V
    logic bias_ok;          // bias power-on detector
    logic code_transition;  // voltage_code reference stepping
  } comp_flags_type;

endpackage

// file: rtl/fault_supervisor.sv
// multiphase fault supervisor: power good, crowbar, PWM state, hiccup
`timescale 1ns/10ps
`default_nettype none
module fault_supervisor #(
  parameter int RETRY_LIMIT = 7
) (
  input  wire logic                          sys_clk,
  input  wire logic                          reset_n,
  input  wire logic                          phase_tick,
  input  wire fault_sup_pkg::comp_flags_type comp_flags,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               power_good_out,
  output logic                               power_good_oe,
  output logic                               crowbar_gate_out,
  output fault_sup_pkg::pwm_mode_type        pwm_mode
);
  import fault_sup_pkg::*;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  comp_flags_type sync1_reg;
  comp_flags_type sync2_reg;

  // two-stage sampling of the comparator flags; only sync2 is used
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= comp_flags;
      sync2_reg <= sync1_reg;
    end
  end

  logic uv;
  logic ov;
  logic at_ref;
  logic oc_raw;
  logic oc;
  logic enabled;
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;

  // blanking hides charging current during reference stepping
  always_comb begin
    uv      = sync2_reg.under_voltage;
    ov      = sync2_reg.over_voltage;
    at_ref  = sync2_reg.at_reference;
    oc_raw  = sync2_reg.over_current;
    enabled = sync2_reg.enable_ok && sync2_reg.bias_ok && ctrl_reg[CTRL_SOFT_EN_BIT];
    oc      = oc_raw
              && !(ctrl_reg[CTRL_BLANK_EN_BIT] && sync2_reg.code_transition);
  end

  // ************************************************************
  // supervisor state machine
  // ************************************************************
  sup_state_type state_reg;
  sup_state_type state_next;
  logic [10:0]   count_reg;
  logic [10:0]   count_next;
  logic [2:0]    retry_reg;
  logic [2:0]    retry_next;
  logic          pwm_low_reg;
  logic          pwm_low_next;
  logic          pg_reg;
  logic          pg_next;
  logic          crowbar_reg;
  logic          crowbar_next;
  logic          ov_seen_reg;
  logic          ov_seen_next;
  logic          oc_seen_reg;
  logic          oc_seen_next;

  // next state; outside shutdown, overvoltage outranks everything but loss of enable
  always_comb begin
    state_next   = state_reg;
    count_next   = count_reg;
    retry_next   = retry_reg;
    pwm_low_next = pwm_low_reg;
    crowbar_next = crowbar_reg;
    ov_seen_next = ov_seen_reg;
    oc_seen_next = oc_seen_reg;
    case (state_reg)
      ST_SHUTDOWN: begin
        count_next = '0;
        if (enabled) begin
          state_next = ST_SOFTSTART;
        end
      end
      ST_SOFTSTART: begin
        if (phase_tick) begin
          count_next = count_reg + 11'h001;
        end
        if (oc) begin
          count_next = '0;
          if (retry_reg == RETRY_LIMIT[2:0]) begin
            state_next = ST_OC_LATCH;
          end else begin
            retry_next = retry_reg + 3'h1;
            state_next = ST_OC_WAIT;
          end
        end else if (phase_tick && count_reg == SS_LAST_COUNT) begin
          retry_next = '0;
          // a recovered start forgets old trips, so a later disable holds power good
          oc_seen_next = 1'b0;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (oc) begin
          count_next = '0;
          if (retry_reg == RETRY_LIMIT[2:0]) begin
            state_next = ST_OC_LATCH;
          end else begin
            retry_next = retry_reg + 3'h1;
            state_next = ST_OC_WAIT;
          end
        end
      end
      ST_OC_WAIT: begin
        if (phase_tick) begin
          count_next = count_reg + 11'h001;
          if (count_reg == WAIT_LAST_COUNT) begin
            count_next = '0;
            state_next = ST_SOFTSTART;
          end
        end
      end
      ST_OC_LATCH: begin
        count_next = '0;
      end
      ST_OV_LATCH: begin
        // low until sense reaches reference, low again on recurrence
        if (ov) begin
          pwm_low_next = 1'b1;
        end else if (at_ref) begin
          pwm_low_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_SHUTDOWN;
      end
    endcase
    if (oc) begin
      oc_seen_next = 1'b1;
    end
    if (ov && state_reg != ST_SHUTDOWN) begin
      state_next   = ST_OV_LATCH;
      pwm_low_next = 1'b1;
      crowbar_next = 1'b1;
    end
    if (!enabled) begin
      state_next   = ST_SHUTDOWN;
      retry_next   = '0;
      pwm_low_next = 1'b0;
      crowbar_next = 1'b0;
      oc_seen_next = 1'b0;
    end
    ov_seen_next = (state_next == ST_OV_LATCH);
  end

  // power good; held high after disable until the output decays, except when disabled during a retried soft start
  always_comb begin
    pg_next = 1'b0;
    case (state_next)
      ST_SOFTSTART: pg_next = !uv && !oc;
      ST_RUN:       pg_next = !uv;
      ST_SHUTDOWN:  pg_next = pg_reg && !uv && !ov_seen_reg && !oc_seen_reg;
      default:      pg_next = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= ST_SHUTDOWN;
      count_reg   <= '0;
      retry_reg   <= '0;
      pwm_low_reg <= 1'b0;
      pg_reg      <= 1'b0;
      crowbar_reg <= 1'b0;
      ov_seen_reg <= 1'b0;
      oc_seen_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      count_reg   <= count_next;
      retry_reg   <= retry_next;
      pwm_low_reg <= pwm_low_next;
      pg_reg      <= pg_next;
      crowbar_reg <= crowbar_next;
      ov_seen_reg <= ov_seen_next;
      oc_seen_reg <= oc_seen_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // open-drain power good: enable pulls low whenever good is false
  always_comb begin
    power_good_out   = 1'b0;
    power_good_oe    = !pg_reg;
    crowbar_gate_out = crowbar_reg;
    case (state_reg)
      ST_SOFTSTART: pwm_mode = PWM_NORMAL;
      ST_RUN:       pwm_mode = PWM_NORMAL;
      ST_OV_LATCH:  pwm_mode = pwm_low_reg ? PWM_LOW : PWM_HIZ;
      default:      pwm_mode = PWM_HIZ;
    endcase
  end

  // ************************************************************
  // APB slave, zero wait states
  // ************************************************************
  logic [31:0] prdata_next;
  logic        pslverr_next;

  function automatic logic addr_known(input logic [11:0] a);
    return (a == CTRL_OFFSET) || (a == STATUS_OFFSET) || (a == RETRY_OFFSET);
  endfunction

  // reads show live state; only control is writable
  always_comb begin
    ctrl_next    = ctrl_reg;
    prdata_next  = prdata;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      pslverr_next = !addr_known(paddr);
      case (paddr)
        CTRL_OFFSET:   prdata_next = {30'h0, ctrl_reg};
        STATUS_OFFSET: prdata_next = {24'h0, crowbar_reg, pg_reg, pwm_mode, 1'b0, state_reg};
        RETRY_OFFSET:  prdata_next = {29'h0, retry_reg};
        default:       prdata_next = 32'h0;
      endcase
    end
    if (psel && penable && pwrite && paddr == CTRL_OFFSET) begin
      ctrl_next = pwdata[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RESET_VALUE;
      prdata   <= '0;
      pslverr  <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata   <= prdata_next;
      pslverr  <= pslverr_next;
    end
  end

  assign pready = 1'b1;

  // ************************************************************
  // assertions
  // ************************************************************
  // span of the current state in phase ticks; restarts on every change of state
  // kept apart from count_reg so that the timing checks do not lean on the counter they judge
  logic [11:0] span_reg;
  logic [11:0] span_next;

  always_comb begin
    span_next = span_reg;
    if (state_next != state_reg) begin
      span_next = '0;
    end else if (phase_tick) begin
      span_next = span_reg + 12'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      span_reg <= '0;
    end else begin
      span_reg <= span_next;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // overvoltage: fault report, lower switches on, input crowbar, latch
  AST_OV_PG_LOW: assert property (ov && state_reg != ST_SHUTDOWN && enabled
    |=> !pg_reg)
    else $error("power good high after overvoltage");
  AST_OV_PWM_LOW: assert property (ov && state_reg != ST_SHUTDOWN && enabled
    |=> pwm_mode == PWM_LOW)
    else $error("pwm not low after overvoltage");
  AST_OV_RELEASE_HIZ: assert property (state_reg == ST_OV_LATCH && at_ref && !ov
    && enabled |=> pwm_mode == PWM_HIZ)
    else $error("pwm not released at reference");
  AST_OV_REPEAT: assert property (state_reg == ST_OV_LATCH && ov && enabled
    |=> pwm_mode == PWM_LOW)
    else $error("pwm not low on repeated overvoltage");
  AST_OV_CROWBAR: assert property (state_reg == ST_OV_LATCH
    |-> crowbar_gate_out)
    else $error("crowbar off in overvoltage latch");
  AST_OV_QUIET: assert property (state_reg == ST_OV_LATCH
    |-> !pg_reg && pwm_mode != PWM_NORMAL)
    else $error("switching or power good in overvoltage latch");
  AST_OV_STAYS: assert property (state_reg == ST_OV_LATCH && enabled
    |=> state_reg == ST_OV_LATCH)
    else $error("overvoltage latch released while enabled");
  AST_CROWBAR_CLEAR: assert property (state_reg == ST_SHUTDOWN
    |-> !crowbar_gate_out)
    else $error("crowbar still on in shutdown");

  // overcurrent: tri-state, wait, restart, count and latch off
  AST_RUN_OC: assert property (state_reg == ST_RUN && oc && !ov && enabled
    |=> pwm_mode == PWM_HIZ && !pg_reg)
    else $error("no shutdown on overcurrent in run");
  AST_OC_WAIT_QUIET: assert property (state_reg == ST_OC_WAIT
    |-> pwm_mode == PWM_HIZ && !pg_reg)
    else $error("pwm or power good active during hiccup wait");
  AST_WAIT_SPAN: assert property (state_reg == ST_OC_WAIT && state_next == ST_SOFTSTART
    |-> span_reg == {1'b0, WAIT_LAST_COUNT} && phase_tick)
    else $error("hiccup wait not 2048 phase ticks");
  AST_OC_HIZ: assert property (state_reg == ST_SOFTSTART && oc && !ov && enabled
    |=> pwm_mode == PWM_HIZ)
    else $error("pwm not tri-stated on overcurrent");
  AST_RETRY_MAX: assert property (retry_reg <= RETRY_LIMIT[2:0])
    else $error("retry count above limit");
  AST_OC_LATCH_HOLD: assert property (state_reg == ST_OC_LATCH && enabled && !ov
    |=> state_reg == ST_OC_LATCH)
    else $error("overcurrent latch released");
  AST_RUN_CLEARS: assert property ($rose(state_reg == ST_RUN)
    |-> retry_reg == 3'h0)
    else $error("retry count not cleared");
  AST_BLANKED: assert property (state_reg == ST_RUN && enabled && !ov && oc_raw
    && ctrl_reg[CTRL_BLANK_EN_BIT] && sync2_reg.code_transition |=> state_reg == ST_RUN)
    else $error("overcurrent tripped during code transition");
  AST_SS_SPAN: assert property (state_reg == ST_SOFTSTART && state_next == ST_RUN
    |-> span_reg == {1'b0, SS_LAST_COUNT} && phase_tick)
    else $error("soft-start not 2048 phase ticks");

  // power good window
  AST_SS_PG: assert property (state_reg == ST_SOFTSTART && !uv && !oc && !ov
    && enabled |=> pg_reg)
    else $error("power good not raised in soft-start");
  AST_UV_RUN: assert property (state_reg == ST_RUN && uv && enabled && !ov && !oc
    |=> !pg_reg && pwm_mode == PWM_NORMAL)
    else $error("undervoltage handling wrong");
  AST_UV_RECOVER: assert property (state_reg == ST_RUN && !uv && !oc && !ov
    && enabled |=> pg_reg)
    else $error("power good not restored");
  AST_DISABLE_HOLD: assert property (state_reg == ST_RUN && pg_reg && !enabled
    && !uv && !ov && !oc |=> pg_reg)
    else $error("power good dropped before output decayed");
  AST_SHUTDOWN_PG: assert property ($rose(pg_reg)
    |-> state_reg != ST_SHUTDOWN)
    else $error("power good rose in shutdown");

  COV_RUN:   cover property (state_reg == ST_SOFTSTART ##1 state_reg == ST_RUN);
  COV_HICCUP: cover property (state_reg == ST_OC_WAIT ##1 state_reg == ST_SOFTSTART);
  COV_OCLATCH: cover property (state_reg == ST_OC_LATCH);
  COV_OV:    cover property (pwm_mode == PWM_LOW ##[1:20] pwm_mode == PWM_HIZ);
  COV_OV_AGAIN: cover property (state_reg == ST_OV_LATCH && pwm_mode == PWM_HIZ ##1 pwm_mode == PWM_LOW);

endmodule
`default_nettype wire
